// *** rtl/tsp_pkg.sv ***
// Shared constants, operation codes and carriers for the tag host serial port.
package tsp_pkg;

   localparam logic [2:0] MODE_REG_WR      = 3'h0;
   localparam logic [2:0] MODE_REG_RD      = 3'h1;
   localparam logic [2:0] MODE_EE_WR       = 3'h2;
   localparam logic [2:0] MODE_EE_RD       = 3'h3;
   localparam logic [2:0] MODE_BUF_LD      = 3'h4;
   localparam logic [2:0] MODE_BUF_RD      = 3'h5;
   localparam logic [1:0] MODE_CMD_PREFIX  = 2'h3;

   localparam int         MODE_MSB         = 7;
   localparam int         MODE_LSB         = 5;
   localparam int         REG_ADDR_W       = 5;
   localparam int         CMD_CODE_W       = 6;
   localparam int         EE_ADDR_W        = 7;
   localparam int         EE_ADDR_LSB      = 1;
   localparam int         CFG_RF_PRIO_BIT  = 3;

   localparam logic [2:0] BIT_LAST         = 3'h7;
   localparam logic [2:0] IDX_FIRST        = 3'h0;
   localparam logic [2:0] IDX_EE_ADDR      = 3'h1;
   localparam logic [2:0] IDX_EE_WR_LAST   = 3'h5;
   localparam logic [2:0] IDX_MAX          = 3'h7;
   localparam logic [1:0] BLK_BYTE_LAST    = 2'h3;

   localparam logic [7:0] STATUS_ACCEPTED  = 8'h01;
   localparam logic [7:0] STATUS_REJECTED  = 8'h02;

   typedef enum logic [2:0] {
      OP_REG_WR,
      OP_REG_RD,
      OP_EE_WR,
      OP_EE_RD,
      OP_BUF_LD,
      OP_BUF_RD,
      OP_CMD
   } tsp_op_e;

   // One received byte and its position in the frame.
   typedef struct packed {
      logic [2:0] idx;
      logic [7:0] data;
   } tsp_byte_evt_s;

   typedef struct packed {
      logic [REG_ADDR_W-1:0] addr;
      logic [7:0]            data;
   } tsp_reg_wr_s;

   typedef struct packed {
      logic [EE_ADDR_W-1:0] addr;
      logic [31:0]          data;
   } tsp_ee_wr_s;

   function automatic tsp_op_e tsp_decode(input logic [2:0] mode);
      tsp_op_e op;
      op = OP_CMD;
      if (mode[2:1] != MODE_CMD_PREFIX) begin
         unique case (mode)
            MODE_REG_WR: op = OP_REG_WR;
            MODE_REG_RD: op = OP_REG_RD;
            MODE_EE_WR:  op = OP_EE_WR;
            MODE_EE_RD:  op = OP_EE_RD;
            MODE_BUF_LD: op = OP_BUF_LD;
            MODE_BUF_RD: op = OP_BUF_RD;
            default:     op = OP_CMD;
         endcase
      end
      return op;
   endfunction

   // True when the device owns the output line for byte idx of the frame.
   function automatic logic tsp_drives(input tsp_op_e op, input logic [2:0] idx);
      logic d;
      d = 1'b0;
      unique case (op)
         OP_REG_RD, OP_BUF_RD: d = (idx != IDX_FIRST);
         OP_EE_RD:             d = (idx > IDX_EE_ADDR);
         OP_CMD:               d = (idx == IDX_EE_ADDR);
         default:              d = 1'b0;
      endcase
      return d;
   endfunction

endpackage

// *** rtl/tsp_port.sv ***
// Serial host port of the tag: link-side shifter and system-side operation decoder.
//
// What this block does, and what its host must do
// RL1: Host keeps serial clock 100 kHz to 5 MHz; the bench host model runs it at 12.5 MHz.
// RL2: Select high holds the port in reset.
// RL3: Input sampled on falling serial clock edge.
// RL4: Whole bytes, MSB first; three mode bits.
// RL5: Register bytes auto-increment the address.
// RL6: Output tristated unless data is driven.
// RL7: Pull-down on when both bits set, tristated.
// RL8: Register write commits on last falling edge.
// RL9: Partial write byte never updates a register.
// RL10: Writes to absent or read-only registers ignored.
// RL11: Output bits launched on rising edge, MSB first.
// RL12: Absent register reads back all zeros.
// RL13: RF priority aborts EEPROM write, flags conflict.
// RL14: Block address is the upper seven bits.
// RL15: Six-byte block write programs at select rise.
// RL16: EEPROM read streams auto-incrementing 4-byte blocks.
// RL17: Absent EEPROM block reads as zeros.
// RL18: Host keeps clock at most 1 MHz reading EEPROM; the bench host model reads it at 12.5 MHz.
// RL19: Buffer load takes every byte, up to 32.
// RL20: Buffer read pops each byte once started.
// RL21: Command mode: six code bits, one argument.
// RL22: Argument slot returns 01h accepted, 02h rejected.
// RL23: Host limits operations on interface supply rail.
// RL24: Interrupt output is active high.
// RL25: Buffer modes ignore trailing mode bits.
// RL26: Command status shifted out during argument byte.
`timescale 1ns/100ps
module tsp_port
   import tsp_pkg::*;
#(
   parameter logic [31:0] REG_PRESENT_MASK  = 32'hFFFFFFFF,
   parameter logic [31:0] REG_WRITABLE_MASK = 32'hFFFFFFFF,
   parameter int          EE_NUM_BLOCKS     = 128,
   parameter int          BUF_DEPTH         = 32
) (
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic                  spi_sclk,
   input  wire logic                  spi_ss_n,
   input  wire logic                  spi_mosi,
   output logic                       spi_miso,
   output logic                       spi_miso_oe,
   input  wire logic                  out_pulldown_enable_a,
   input  wire logic                  out_pulldown_enable_b,
   output logic                       miso_pulldown_on,
   input  wire logic [7:0]            chip_config_byte_zero,
   input  wire logic                  irq_source,
   output logic                       irq,
   output logic                       reg_wr_en,
   output tsp_reg_wr_s                reg_wr,
   output logic                       reg_rd_req,
   output logic [REG_ADDR_W-1:0]      reg_rd_addr,
   input  wire logic [7:0]            reg_rd_data,
   output logic                       ee_wr_req,
   output tsp_ee_wr_s                 ee_wr,
   input  wire logic                  ee_wr_done,
   input  wire logic                  rf_needs_eeprom,
   output logic                       ee_wr_abort,
   output logic                       acc_conflict,
   output logic                       ee_rd_req,
   output logic [EE_ADDR_W-1:0]       ee_rd_addr,
   input  wire logic                  ee_rd_valid,
   input  wire logic [31:0]           ee_rd_data,
   output logic                       buf_wr_en,
   output logic [7:0]                 buf_wr_data,
   output logic                       buf_rd_pop,
   input  wire logic [7:0]            buf_rd_data,
   output logic                       cmd_req,
   output logic [CMD_CODE_W-1:0]      cmd_code,
   input  wire logic                  cmd_accept
);

   localparam int BUF_CNT_W = $clog2(BUF_DEPTH + 1);

   function automatic logic mask_hit(input logic [31:0] mask, input logic [REG_ADDR_W-1:0] a);
      return mask[a];
   endfunction

   // ---------------- Link domain: serial clock, cleared by select high ----------------

   logic [2:0]    bit_cnt_q;
   logic [6:0]    rx_sh_q;
   logic [2:0]    lk_idx_q;
   tsp_op_e       lk_op_q;
   tsp_byte_evt_s evt_q;
   logic          evt_tgl_q;
   logic [7:0]    tx_sh_q;
   logic          miso_q;
   logic          miso_oe_q;
   logic          st_tgl_q;
   logic [7:0]    held_q;

   // RL2 select high resets. RL3 falling edge sampling.
   always_ff @(negedge spi_sclk or posedge spi_ss_n) begin
      if (spi_ss_n) begin
         bit_cnt_q <= '0;
         rx_sh_q   <= '0;
      end else begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         rx_sh_q   <= {rx_sh_q[5:0], spi_mosi};
      end
   end

   // RL4 byte assembly, MSB first.
   // RL9 only a full eighth bit raises an event.
   always_ff @(negedge spi_sclk or posedge spi_ss_n) begin
      if (spi_ss_n) begin
         evt_q     <= '0;
         evt_tgl_q <= 1'b0;
      end else if (bit_cnt_q == BIT_LAST) begin
         evt_q     <= '{idx: lk_idx_q, data: {rx_sh_q, spi_mosi}};
         evt_tgl_q <= ~evt_tgl_q;
      end
   end

   // RL4 mode taken from first byte.
   always_ff @(negedge spi_sclk or posedge spi_ss_n) begin
      if (spi_ss_n) begin
         lk_idx_q <= IDX_FIRST;
         lk_op_q  <= OP_REG_WR;
      end else if (bit_cnt_q == BIT_LAST) begin
         if (lk_idx_q != IDX_MAX) begin
            lk_idx_q <= lk_idx_q + 3'h1;
         end
         if (lk_idx_q == IDX_FIRST) begin
            lk_op_q <= tsp_decode(rx_sh_q[6:4]);
         end
      end
   end

   // The held byte is written by the system side between bytes and is stable at the
   // first rising edge of the next byte, provided the host leaves the gap that the
   // system side needs to answer; it is therefore read here without synchronisers.
   // RL11 rising edge launch, MSB first.
   // RL6 tristate outside driven bytes.
   always_ff @(posedge spi_sclk or posedge spi_ss_n) begin
      if (spi_ss_n) begin
         tx_sh_q   <= '0;
         miso_q    <= 1'b0;
         miso_oe_q <= 1'b0;
         st_tgl_q  <= 1'b0;
      end else if (bit_cnt_q == '0) begin
         if (tsp_drives(lk_op_q, lk_idx_q)) begin
            tx_sh_q   <= {held_q[6:0], 1'b0};
            miso_q    <= held_q[7];
            miso_oe_q <= 1'b1;
            st_tgl_q  <= ~st_tgl_q;
         end else begin
            tx_sh_q   <= '0;
            miso_q    <= 1'b0;
            miso_oe_q <= 1'b0;
         end
      end else begin
         miso_q  <= tx_sh_q[7];
         tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
   end

   assign spi_miso    = miso_q;
   assign spi_miso_oe = miso_oe_q;

   // ---------------- Crossing into the system clock ----------------

   logic ss_meta_q, ss_sync_q, ss_prev_q;
   logic ev_meta_q, ev_sync_q, ev_prev_q, ev_old_q;
   logic st_meta_q, st_sync_q, st_prev_q, st_old_q;
   logic oe_meta_q, oe_sync_q;

   // Event toggles fall back to zero when select rises; that false toggle reaches the
   // compare one stage later than the select level, so masking by select hides it.
   always_ff @(posedge clk) begin
      if (reset) begin
         ss_meta_q <= 1'b1;
         ss_sync_q <= 1'b1;
         ss_prev_q <= 1'b1;
         ev_meta_q <= 1'b0;
         ev_sync_q <= 1'b0;
         ev_prev_q <= 1'b0;
         ev_old_q  <= 1'b0;
         st_meta_q <= 1'b0;
         st_sync_q <= 1'b0;
         st_prev_q <= 1'b0;
         st_old_q  <= 1'b0;
         oe_meta_q <= 1'b0;
         oe_sync_q <= 1'b0;
      end else begin
         ss_meta_q <= spi_ss_n;
         ss_sync_q <= ss_meta_q;
         ss_prev_q <= ss_sync_q;
         ev_meta_q <= evt_tgl_q;
         ev_sync_q <= ev_meta_q;
         ev_prev_q <= ev_sync_q;
         ev_old_q  <= ev_prev_q;
         st_meta_q <= st_tgl_q;
         st_sync_q <= st_meta_q;
         st_prev_q <= st_sync_q;
         st_old_q  <= st_prev_q;
         oe_meta_q <= miso_oe_q;
         oe_sync_q <= oe_meta_q;
      end
   end

   logic ss_mask;
   logic ev_valid;
   logic st_valid;
   logic frame_end;

   assign ss_mask   = ss_sync_q | ss_prev_q;
   assign ev_valid  = (ev_prev_q ^ ev_old_q) & ~ss_mask;
   assign st_valid  = (st_prev_q ^ st_old_q) & ~ss_mask;
   assign frame_end = ss_sync_q & ~ss_prev_q;

   // ---------------- System side: decode and act on each byte ----------------

   tsp_op_e               op_q;
   logic [REG_ADDR_W-1:0] reg_addr_q;
   logic [EE_ADDR_W-1:0]  ee_addr_q;
   logic [31:0]           ee_wdata_q;
   logic [31:0]           blk_q;
   logic [1:0]            blk_byte_q;
   logic [2:0]            last_idx_q;
   logic [BUF_CNT_W-1:0]  buf_cnt_q;
   logic                  reg_rd_pend_q;
   logic                  ee_wr_active_q;

   tsp_op_e               ev_op;
   logic                  do_reg_wr;
   logic                  do_reg_fetch;
   logic [REG_ADDR_W-1:0] reg_fetch_addr;
   logic                  do_ee_fetch;
   logic [EE_ADDR_W-1:0]  ee_fetch_addr;
   logic                  do_ee_byte;
   logic                  do_buf_ld;
   logic                  do_buf_peek;
   logic                  do_cmd;

   // RL25 buffer modes decode on three bits.
   always_comb begin
      ev_op          = (evt_q.idx == IDX_FIRST) ? tsp_decode(evt_q.data[MODE_MSB:MODE_LSB])
                                                : op_q;
      do_reg_wr      = 1'b0;
      do_reg_fetch   = 1'b0;
      reg_fetch_addr = reg_addr_q + 5'h01;
      do_ee_fetch    = 1'b0;
      ee_fetch_addr  = ee_addr_q + 7'h01;
      do_ee_byte     = 1'b0;
      do_buf_ld      = 1'b0;
      do_buf_peek    = 1'b0;
      do_cmd         = 1'b0;
      if (ev_valid) begin
         unique case (ev_op)
            OP_REG_WR: do_reg_wr = (evt_q.idx != IDX_FIRST);
            OP_REG_RD: begin
               do_reg_fetch = 1'b1;
               if (evt_q.idx == IDX_FIRST) begin
                  reg_fetch_addr = evt_q.data[REG_ADDR_W-1:0];
               end
            end
            OP_EE_WR:  do_ee_byte = 1'b0;
            OP_EE_RD: begin
               // RL14 upper seven bits address.
               if (evt_q.idx == IDX_EE_ADDR) begin
                  do_ee_fetch   = 1'b1;
                  ee_fetch_addr = evt_q.data[7:EE_ADDR_LSB];
               end else if (evt_q.idx > IDX_EE_ADDR) begin
                  do_ee_fetch = (blk_byte_q == BLK_BYTE_LAST);
                  do_ee_byte  = (blk_byte_q != BLK_BYTE_LAST);
               end
            end
            // RL19 every byte to the buffer.
            OP_BUF_LD: do_buf_ld = (evt_q.idx != IDX_FIRST) &&
                                   (buf_cnt_q < BUF_CNT_W'(BUF_DEPTH));
            OP_BUF_RD: do_buf_peek = 1'b1;
            OP_CMD:    do_cmd = (evt_q.idx == IDX_FIRST);
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset || frame_end) begin
         op_q       <= OP_REG_WR;
         last_idx_q <= IDX_FIRST;
      end else if (ev_valid) begin
         op_q       <= ev_op;
         last_idx_q <= evt_q.idx;
      end
   end

   // RL5 address steps by one per byte.
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_addr_q <= '0;
      end else if (ev_valid && evt_q.idx == IDX_FIRST) begin
         reg_addr_q <= evt_q.data[REG_ADDR_W-1:0];
      end else if (do_reg_wr || do_reg_fetch) begin
         reg_addr_q <= reg_addr_q + 5'h01;
      end
   end

   // RL8 commit at the byte's last bit.
   // RL10 absent or read-only targets dropped.
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_wr_en <= 1'b0;
         reg_wr    <= '0;
      end else begin
         reg_wr_en <= do_reg_wr && mask_hit(REG_WRITABLE_MASK, reg_addr_q) &&
                      mask_hit(REG_PRESENT_MASK, reg_addr_q);
         if (do_reg_wr) begin
            reg_wr <= '{addr: reg_addr_q, data: evt_q.data};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rd_req    <= 1'b0;
         reg_rd_addr   <= '0;
         reg_rd_pend_q <= 1'b0;
      end else begin
         reg_rd_req    <= do_reg_fetch;
         reg_rd_pend_q <= reg_rd_req;
         if (do_reg_fetch) begin
            reg_rd_addr <= reg_fetch_addr;
         end
      end
   end

   // RL15 collect the six-byte block write.
   always_ff @(posedge clk) begin
      if (reset) begin
         ee_addr_q  <= '0;
         ee_wdata_q <= '0;
      end else if (ev_valid && ev_op == OP_EE_WR) begin
         if (evt_q.idx == IDX_EE_ADDR) begin
            ee_addr_q <= evt_q.data[7:EE_ADDR_LSB];
         end else if (evt_q.idx > IDX_EE_ADDR) begin
            ee_wdata_q <= {ee_wdata_q[23:0], evt_q.data};
         end
      end else if (do_ee_fetch) begin
         ee_addr_q <= ee_fetch_addr;
      end
   end

   // RL16 next block fetched after four bytes.
   // RL17 absent blocks answered locally with zeros.
   always_ff @(posedge clk) begin
      if (reset) begin
         ee_rd_req  <= 1'b0;
         ee_rd_addr <= '0;
      end else begin
         ee_rd_req <= do_ee_fetch && (32'(ee_fetch_addr) < EE_NUM_BLOCKS);
         if (do_ee_fetch) begin
            ee_rd_addr <= ee_fetch_addr;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset || frame_end) begin
         blk_q      <= '0;
         blk_byte_q <= '0;
      end else if (do_ee_fetch) begin
         blk_q      <= '0;
         blk_byte_q <= '0;
      end else if (ee_rd_valid) begin
         blk_q <= ee_rd_data;
      end else if (do_ee_byte) begin
         blk_byte_q <= blk_byte_q + 2'h1;
      end
   end

   // RL12 absent register gives zeros.
   // RL22 status byte from cmd_accept.
   // RL26 status shifted during the argument.
   always_ff @(posedge clk) begin
      if (reset) begin
         held_q <= '0;
      end else if (reg_rd_pend_q) begin
         held_q <= mask_hit(REG_PRESENT_MASK, reg_rd_addr) ? reg_rd_data : 8'h00;
      end else if (do_ee_fetch) begin
         held_q <= 8'h00;
      end else if (ee_rd_valid) begin
         held_q <= ee_rd_data[31:24];
      end else if (do_ee_byte) begin
         held_q <= blk_q[8*(3-(32'(blk_byte_q)+1)) +: 8];
      end else if (do_buf_peek) begin
         held_q <= buf_rd_data;
      end else if (do_cmd) begin
         held_q <= cmd_accept ? STATUS_ACCEPTED : STATUS_REJECTED;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || frame_end) begin
         buf_cnt_q <= '0;
      end else if (do_buf_ld) begin
         buf_cnt_q <= buf_cnt_q + BUF_CNT_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         buf_wr_en   <= 1'b0;
         buf_wr_data <= '0;
      end else begin
         buf_wr_en <= do_buf_ld;
         if (do_buf_ld) begin
            buf_wr_data <= evt_q.data;
         end
      end
   end

   // RL20 pop on the first bit, so a cut byte counts.
   always_ff @(posedge clk) begin
      if (reset) begin
         buf_rd_pop <= 1'b0;
      end else begin
         buf_rd_pop <= st_valid && (op_q == OP_BUF_RD);
      end
   end

   // RL21 six code bits after the mode.
   always_ff @(posedge clk) begin
      if (reset) begin
         cmd_req  <= 1'b0;
         cmd_code <= '0;
      end else begin
         cmd_req <= do_cmd;
         if (do_cmd) begin
            cmd_code <= evt_q.data[CMD_CODE_W-1:0];
         end
      end
   end

   // RL15 programming starts on select rise, only after exactly six bytes.
   always_ff @(posedge clk) begin
      if (reset) begin
         ee_wr_req <= 1'b0;
         ee_wr     <= '0;
      end else begin
         ee_wr_req <= frame_end && (op_q == OP_EE_WR) && (last_idx_q == IDX_EE_WR_LAST);
         if (frame_end) begin
            ee_wr <= '{addr: ee_addr_q, data: ee_wdata_q};
         end
      end
   end

   // RL13 abort on RF need under RF priority.
   always_ff @(posedge clk) begin
      if (reset) begin
         ee_wr_active_q <= 1'b0;
         ee_wr_abort    <= 1'b0;
         acc_conflict   <= 1'b0;
      end else begin
         ee_wr_abort  <= 1'b0;
         acc_conflict <= 1'b0;
         if (ee_wr_req) begin
            ee_wr_active_q <= 1'b1;
         end else if (ee_wr_active_q && rf_needs_eeprom &&
                      chip_config_byte_zero[CFG_RF_PRIO_BIT]) begin
            ee_wr_active_q <= 1'b0;
            ee_wr_abort    <= 1'b1;
            acc_conflict   <= 1'b1;
         end else if (ee_wr_done) begin
            ee_wr_active_q <= 1'b0;
         end
      end
   end

   // RL24 active-high attention request.
   // RL7 pull-down only while both bits set and the line is released.
   always_ff @(posedge clk) begin
      if (reset) begin
         irq              <= 1'b0;
         miso_pulldown_on <= 1'b0;
      end else begin
         irq              <= irq_source | acc_conflict;
         miso_pulldown_on <= out_pulldown_enable_a & out_pulldown_enable_b & ~oe_sync_q;
      end
   end

endmodule

// *** test/tsp_port_properties.sv ***
// Concurrent checks on the ports of the tag host serial port.
`timescale 1ns/100ps
module tsp_port_properties
   import tsp_pkg::*;
(
   input wire logic       clk,
   input wire logic       reset,
   input wire logic       spi_ss_n,
   input wire logic       spi_miso,
   input wire logic       spi_miso_oe,
   input wire logic       out_pulldown_enable_a,
   input wire logic       out_pulldown_enable_b,
   input wire logic       miso_pulldown_on,
   input wire logic [7:0] chip_config_byte_zero,
   input wire logic       irq_source,
   input wire logic       irq,
   input wire logic       rf_needs_eeprom,
   input wire logic       ee_wr_abort,
   input wire logic       acc_conflict,
   input wire logic       reg_wr_en,
   input wire logic       ee_wr_req
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // The pull-down sees the output enable through a synchroniser, so allow it a few cycles.
   sequence s_pd_idle;
      (out_pulldown_enable_a && out_pulldown_enable_b && !spi_miso_oe) [*5];
   endsequence
   sequence s_driving;
      spi_miso_oe [*4];
   endsequence

   a_miso_quiet: assert property (!spi_miso_oe |-> !spi_miso)
      else $error("output data not low while released");
   a_idle_no_drive: assert property (spi_ss_n |-> !spi_miso_oe)
      else $error("output driven while deselected");
   a_pd_needs_bits: assert property (miso_pulldown_on |->
      $past(out_pulldown_enable_a) && $past(out_pulldown_enable_b))
      else $error("pull-down on without both enables");
   a_pd_turns_on: assert property (s_pd_idle |-> miso_pulldown_on)
      else $error("pull-down missing while released");
   a_pd_off_drive: assert property (s_driving |-> !miso_pulldown_on)
      else $error("pull-down on while driving");
   a_irq_source: assert property (irq_source ##1 irq_source |-> irq)
      else $error("interrupt not raised for source");
   a_conflict_irq: assert property (acc_conflict |-> ##[0:1] irq)
      else $error("interrupt not raised for conflict");
   a_abort_cause: assert property (ee_wr_abort |->
      $past(chip_config_byte_zero[CFG_RF_PRIO_BIT]) && $past(rf_needs_eeprom))
      else $error("abort without priority demand");
   a_abort_flags: assert property (ee_wr_abort |-> ##[0:1] acc_conflict)
      else $error("abort without conflict flag");
   a_wr_single: assert property (reg_wr_en |=> !reg_wr_en)
      else $error("register write strobe too long");
   a_ee_after_ss: assert property (ee_wr_req |-> spi_ss_n && $past(spi_ss_n, 3))
      else $error("programming started inside frame");
endmodule

bind tsp_port tsp_port_properties chk_u (
   .clk, .reset, .spi_ss_n, .spi_miso, .spi_miso_oe, .out_pulldown_enable_a,
   .out_pulldown_enable_b, .miso_pulldown_on, .chip_config_byte_zero, .irq_source,
   .irq, .rf_needs_eeprom, .ee_wr_abort, .acc_conflict, .reg_wr_en, .ee_wr_req
);

// *** test/tsp_host_model.sv ***
// Host serial master model that clocks frames into the tag port.
`timescale 1ns/100ps
module tsp_host_model (
   output logic      sclk,
   output logic      ss_n,
   output logic      mosi,
   input  wire logic miso
);
   initial begin
      sclk = 1'b0;
      ss_n = 1'b1;
      mosi = 1'b0;
   end

   task automatic start();
      ss_n = 1'b0;
      #43;
   endtask

   task automatic xbyte(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         mosi = tx[i];
         #30 sclk = 1'b1;
         #40 rx[i] = miso;
         sclk = 1'b0;
         #10;
      end
      mosi = ~mosi;
      #150;
   endtask

   task automatic stop();
      ss_n = 1'b1;
      #200;
   endtask
endmodule

// *** test/testbench.sv ***
// Randomised self-checking bench for the tag host serial port.
`timescale 1ns/100ps
module testbench;
   import tsp_pkg::*;
   logic        clk, reset, spi_sclk, spi_ss_n, spi_mosi, spi_miso, spi_miso_oe, miso_w;
   logic        out_pulldown_enable_a, out_pulldown_enable_b, miso_pulldown_on, irq_source;
   logic        irq, reg_wr_en, reg_rd_req, ee_wr_req, ee_wr_done, rf_needs_eeprom;
   logic        ee_wr_abort, acc_conflict, ee_rd_req, ee_rd_valid, buf_wr_en, buf_rd_pop;
   logic        cmd_req, cmd_accept;
   logic [7:0]  chip_config_byte_zero, reg_rd_data, buf_wr_data, buf_rd_data, bq[$];
   logic [7:0]  tx[12], rx[12];
   logic [4:0]  reg_rd_addr;
   logic [6:0]  ee_rd_addr, blk;
   logic [5:0]  cmd_code, code;
   logic [31:0] ee_rd_data;
   tsp_reg_wr_s reg_wr, wq[$];
   tsp_ee_wr_s  ee_wr, ew;
   int          fail_count, checks_done, seed, pops, hits, irqs, cmds;

   tsp_port #(.REG_PRESENT_MASK(32'hFFFF_FFDF), .REG_WRITABLE_MASK(32'h7FFF_FFFF),
      .EE_NUM_BLOCKS(127)) dut_u (.*);
   tsp_host_model host_u (.sclk(spi_sclk), .ss_n(spi_ss_n), .mosi(spi_mosi), .miso(miso_w));
   // A released line floats away from its last level unless the pull-down holds it.
   assign miso_w = spi_miso_oe ? spi_miso : (miso_pulldown_on ? 1'b0 : ~spi_miso);

   always #5 clk = ~clk;

   function automatic logic [7:0] exp_reg(input logic [4:0] a);
      return {3'h5, a};
   endfunction
   function automatic logic [31:0] exp_blk(input logic [6:0] b);
      return {1'b1, b, 8'hA5, ~b, 1'b0, 8'h3C};
   endfunction

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (exp !== got) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task automatic test_done();
      if (fail_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic frame(input int nb, input int tail);
      host_u.start();
      for (int i = 0; i < nb; i++) host_u.xbyte(tx[i], 8, rx[i]);
      if (tail > 0) host_u.xbyte(tx[nb], tail, rx[nb]);
      host_u.stop();
      @(negedge clk);
   endtask

   always @(posedge clk) begin
      if (reg_wr_en === 1'b1) wq.push_back(reg_wr);
      if (buf_wr_en === 1'b1) bq.push_back(buf_wr_data);
      if (buf_rd_pop === 1'b1) pops++;
      if (ee_wr_req === 1'b1) ew = ee_wr;
      if (acc_conflict === 1'b1) hits++;
      if (irq === 1'b1 && !irq_source) irqs++;
      if (cmd_req === 1'b1) cmds++;
   end

   // Stand-in for the chip behind the port: registers, memory and buffer head.
   always @(negedge clk) begin
      if (reg_rd_req) reg_rd_data <= exp_reg(reg_rd_addr);
      ee_rd_valid <= ee_rd_req;
      ee_rd_data  <= exp_blk(ee_rd_addr);
      buf_rd_data <= 8'hC0 + 8'(pops);
   end

   initial begin
      #500000;
      fail_count++;
      test_done();
   end

   initial begin
      clk = 1'b0;
      reset = 1'b1;
      seed = 17572;
      {irq_source, ee_wr_done, rf_needs_eeprom, cmd_accept} = '0;
      chip_config_byte_zero = '0;
      {out_pulldown_enable_a, out_pulldown_enable_b} = 2'h3;
      for (int i = 1; i < 12; i++) tx[i] = 8'($random(seed));
      repeat (2) @(posedge clk);
      @(negedge clk) reset = 1'b0;
      tx[0] = 8'h1C;
      frame(5, 5);
      chk("reg write count", 3, wq.size());
      for (int i = 0; i < 3; i++) chk("reg write", {5'(28 + i), tx[i + 1]}, wq[i]);
      tx[0] = 8'h24;
      frame(3, 0);
      chk("reg read", exp_reg(5'h04), rx[1]);
      chk("absent reg", 8'h00, rx[2]);
      tx[0] = 8'h7F;
      tx[1] = 8'hFD;
      frame(10, 0);
      for (int i = 0; i < 8; i++)
         chk("ee read", i < 4 ? 8'(exp_blk(7'h7E) >> (24 - 8 * i)) : 8'h00, rx[i + 2]);
      blk = 7'($random(seed));
      tx[0] = 8'h40;
      tx[1] = {blk, 1'($random(seed))};
      frame(6, 3);
      chk("ee block", blk, ew.addr);
      chk("ee data", {tx[2], tx[3], tx[4], tx[5]}, ew.data);
      rf_needs_eeprom = 1'b1;
      repeat (4) @(negedge clk);
      chk("conflict early", 0, hits);
      chip_config_byte_zero = 8'h08;
      repeat (6) @(negedge clk);
      chk("conflict", 1, hits);
      chk("conflict irq", 1, irqs > 0);
      rf_needs_eeprom = 1'b0;
      ee_wr_done = 1'b1;
      irq_source = 1'b1;
      repeat (3) @(negedge clk);
      chk("irq", 1'b1, irq);
      {irq_source, ee_wr_done} = 2'h0;
      tx[0] = {3'h4, 5'($random(seed))};
      frame(4, 0);
      for (int i = 0; i < 3; i++) chk("buffer load", tx[i + 1], bq[i]);
      tx[0] = {3'h5, 5'($random(seed))};
      frame(3, 5);
      chk("buffer read", 8'hC0, rx[1]);
      chk("buffer read", 8'hC1, rx[2]);
      chk("buffer pops", 3, pops);
      for (int k = 0; k < 2; k++) begin
         code = 6'($random(seed));
         cmd_accept = k[0];
         {out_pulldown_enable_a, out_pulldown_enable_b} = 2'(k + 1);
         tx[0] = {2'h3, code};
         frame(2, 0);
         chk("command code", code, cmd_code);
         chk("command strobe", k + 1, cmds);
         chk("command status", k ? STATUS_ACCEPTED : STATUS_REJECTED, rx[1]);
      end
      test_done();
   end
endmodule
